// ---- serial_and_test_pad_control_tb_top.sv ----
`include "stpc_map.svh"
module serial_and_test_pad_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, awv, wv, br, arv, rr, awr, wr_r, bv, arr, rv;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic a_tx, b_tx, a_rx, b_rx, tck, tms, tdi, tms_pu, tdi_pu;
  logic tdo, tdo_oe, tdo_pu, tms_s, tdi_s, sh_st, sh_d;
  logic [3:0] pin, pout, poe, ppu, pdrv, pval, ws;
  int miscompares, compares, edges;
  logic [11:0] pu_adr [6] = '{12'h000, 12'h000, 12'h000,
                              12'h004, 12'h004, 12'h004};
  logic [7:0] pu_dat [6] = '{8'h02, 8'h01, 8'h03, 8'h80, 8'h40, 8'hc0};
  logic [3:0] pu_exp [6] = '{4'he, 4'hd, 4'hf, 4'hb, 4'h7, 4'hf};

  stpc_pad_ctrl DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .serial_a_tx_data(a_tx),
    .serial_b_tx_data(b_tx), .serial_a_rx_data(a_rx),
    .serial_b_rx_data(b_rx), .serial_pad_in(pin), .serial_pad_out(pout),
    .serial_pad_oe(poe), .serial_pad_pullup_en(ppu), .test_clock(tck),
    .test_mode_select(tms), .test_data_in(tdi),
    .test_mode_pullup_en(tms_pu), .test_data_in_pullup_en(tdi_pu),
    .test_data_out(tdo), .test_data_out_oe(tdo_oe),
    .test_data_out_pullup_en(tdo_pu), .test_mode_sampled(tms_s),
    .test_data_in_sampled(tdi_s), .test_shift_state(sh_st),
    .test_shift_data(sh_d));

  stpc_far_side PROBE (.test_clock(tck), .test_mode_select(tms),
    .test_data_in(tdi), .tms_pullup_en(tms_pu), .tdi_pullup_en(tdi_pu),
    .pad_out(pout), .pad_oe(poe), .pad_pullup_en(ppu),
    .peer_drive(pdrv), .peer_val(pval), .pad_in(pin));

  // ****************************************************************
  // Reporting
  // ****************************************************************
  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Bounded wait step
  task automatic stall(inout int n);
    n++;
    if (n > 50) begin
      miscompares++;
      end_of_test();
    end
  endtask

  // ****************************************************************
  // AXI4-Lite master
  // ****************************************************************
  task automatic wr(input logic [11:0] a, input logic [31:0] v,
                    output logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= {20'h0, a};
    wdata <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
      if (bv) begin
        rsp = bresp;
        br <= 1'b0;
        break;
      end
      stall(n);
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v,
                    output logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {20'h0, a};
    arv <= 1'b1;
    rr <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv) begin
        v = rdata;
        rsp = rresp;
        rr <= 1'b0;
        break;
      end
      stall(n);
    end
  endtask

  // Clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Test logic side: next shift bit on rise, captures checked
  always @(posedge tck) begin
    sh_d <= ~sh_d;
    #1;
    check("tms_sampled", tms_s, tms);
    check("tdi_sampled", tdi_s, tdi);
    if (tdo_oe === 1'b1) check("tdo_hold", tdo, !sh_d);
  end

  // Output launched on the fall
  always @(negedge tck) begin
    edges++;
    #1;
    if (edges > 2) check("tdo_oe", tdo_oe, sh_st);
    if (tdo_oe === 1'b1) check("tdo_launch", tdo, sh_d);
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {aresetn, awv, wv, br, arv, rr, a_tx, b_tx, sh_d} = '0;
    {awaddr, wdata, araddr} = '0;
    {miscompares, compares, edges} = '0;
    pdrv = 4'ha;
    pval = 4'hf;
    ws = 4'hf;
    sh_st = 1'b1;
    repeat (10) @(posedge aclk);
    check("oe_rst", poe, 4'h0);
    check("pu_rst", ppu, 4'hf);
    check("tdo_oe_rst", tdo_oe, 1'b0);
    check("tdo_pu", tdo_pu, 1'b1);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    #1 check("oe_serial", poe, 4'h5);
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      a_tx <= i[0];
      b_tx <= i[1];
      pval <= {i[1], 1'b0, i[0], 1'b0};
      repeat (4) @(posedge aclk);
      #1 check("a_tx_pad", pout[0], i[0]);
      check("b_tx_pad", pout[2], i[1]);
      check("b_rx_in", b_rx, i[1]);
      check("a_rx_in", a_rx, i[0]);
    end
    $display("Test serial function done");
    for (int i = 0; i < 6; i++) begin
      wr(pu_adr[i], {24'h0, pu_dat[i]}, r);
      #1 check("pullups", ppu, pu_exp[i]);
      rd(pu_adr[i], d, r);
      check("pullup_read", d, {24'h0, pu_dat[i]});
    end
    for (int j = 1; j >= 0; j--) begin
      wr(`STPC_SYSTEM_PULLUP_DISABLE_ADDR, j, r);
      #1 check("tms_pu", tms_pu, !j[0]);
      check("tdi_pu", tdi_pu, !j[0]);
    end
    // Write with byte lane 0 off must leave the pull-ups alone
    ws <= 4'he;
    wr(`STPC_PORT_E_PULLUP_ENABLE_ADDR, 32'h0, r);
    #1 check("strb_ignored", ppu, 4'hf);
    check("strb_resp", r, stpc_pkg::STPC_RESP_OKAY);
    ws <= 4'hf;
    $display("Test pull-ups done");
    wr(`STPC_PIN_FUNCTION_ADDR, 32'hf, r);
    for (int k = 0; k < 2; k++) begin
      wr(`STPC_GPIO_DIRECTION_ADDR, k ? 32'ha : 32'h5, r);
      wr(`STPC_GPIO_OUTPUT_ADDR, k ? 32'ha : 32'h5, r);
      pdrv <= k ? 4'h5 : 4'ha;
      pval <= 4'h0;
      #1 check("gpio_oe", poe, k ? 4'ha : 4'h5);
      check("gpio_out", pout & poe, poe);
      check("a_rx_gpio", a_rx, 1'b1);
      repeat (3) @(posedge aclk);
      rd(`STPC_PIN_STATUS_ADDR, d, r);
      check("status", d, k ? 32'ha : 32'h5);
    end
    rd(12'h01c, d, r);
    check("bad_read", r, stpc_pkg::STPC_RESP_SLVERR);
    wr(12'h01c, 32'h0, r);
    check("bad_write", r, stpc_pkg::STPC_RESP_SLVERR);
    $display("Test gpio done");
    @(posedge aclk);
    aresetn <= 1'b0;
    @(posedge aclk);
    #1 check("oe_mid_rst", poe, 4'h0);
    check("pu_mid_rst", ppu, 4'hf);
    @(posedge aclk);
    aresetn <= 1'b1;
    pdrv <= 4'ha;
    repeat (2) @(posedge aclk);
    #1 check("oe_after_rst", poe, 4'h5);
    $display("Test second reset done");
    PROBE.frame(8'h5a, 8'h3c);
    #1 check("tdo_oe_shift", tdo_oe, 1'b1);
    @(posedge aclk);
    sh_st <= 1'b0;
    PROBE.frame(8'ha5, 8'hc3);
    #1 check("tdo_oe_idle", tdo_oe, 1'b0);
    $display("Test link done");
    end_of_test();
  end
endmodule

// ---- stpc_far_side.sv ----
// ****************************************************************
// Serial peer and test probe beside the pads
// ****************************************************************
module stpc_far_side (
  output logic test_clock,
  output logic test_mode_select,
  output logic test_data_in,
  input wire logic tms_pullup_en,
  input wire logic tdi_pullup_en,
  input wire logic [3:0] pad_out,
  input wire logic [3:0] pad_oe,
  input wire logic [3:0] pad_pullup_en,
  input wire logic [3:0] peer_drive,
  input wire logic [3:0] peer_val,
  output logic [3:0] pad_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // Test clock stands low between frames
  initial begin
    test_clock = 1'b0;
    test_mode_select = 1'b1;
    test_data_in = 1'b1;
  end

  // One frame of eight bits, 6 ns period, bits set after each fall
  task automatic frame(input logic [7:0] ms, input logic [7:0] di);
    for (int i = 0; i < 8; i++) begin
      test_mode_select = ms[i];
      test_data_in = di[i];
      #3 test_clock = 1'b1;
      #3 test_clock = 1'b0;
    end
    // Released lines: pull-up level, else inverse of the last bit
    test_mode_select = tms_pullup_en ? 1'b1 : ~ms[7];
    test_data_in = tdi_pullup_en ? 1'b1 : ~di[7];
  endtask

  // Pad level from device driver, peer driver or pull-up, else inverse of the pad output
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (peer_drive[i]) pad_in[i] = peer_val[i];
      else pad_in[i] = pad_pullup_en[i] ? 1'b1 : ~pad_out[i];
    end
  end
endmodule

// ---- stpc_map.svh ----
`ifndef STPC_MAP_SVH
`define STPC_MAP_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define STPC_PORT_E_PULLUP_ENABLE_ADDR 12'h000
`define STPC_PORT_D_PULLUP_ENABLE_ADDR 12'h004
`define STPC_SYSTEM_PULLUP_DISABLE_ADDR 12'h008
`define STPC_PIN_FUNCTION_ADDR 12'h00c
`define STPC_GPIO_DIRECTION_ADDR 12'h010
`define STPC_GPIO_OUTPUT_ADDR 12'h014
`define STPC_PIN_STATUS_ADDR 12'h018

// ****************************************************************
// Field positions
// ****************************************************************
`define STPC_PE_LINE_ZERO_BIT 0
`define STPC_PE_LINE_ONE_BIT 1
`define STPC_PD_LINE_SIX_BIT 6
`define STPC_PD_LINE_SEVEN_BIT 7
`define STPC_SPD_TEST_PORT_BIT 0

// ****************************************************************
// Reset values
// ****************************************************************
`define STPC_PORT_E_PULLUP_RESET 2'h3
`define STPC_PORT_D_PULLUP_RESET 2'h3
`define STPC_SYSTEM_PULLUP_RESET 1'h0
`define STPC_PIN_FUNCTION_RESET 4'h0
`define STPC_GPIO_DIRECTION_RESET 4'h0
`define STPC_GPIO_OUTPUT_RESET 4'h0

`endif

// ---- stpc_pad_ctrl.sv ----
`include "stpc_map.svh"
// Function
// - After reset each serial transmit pin carries its serial function.
// - After reset serial channel b receive pin is a serial input.
// - In GPIO mode each serial pin has its own direction bit.
// - Clearing port E pull-up bit 0 drops the serial a transmit pull-up.
// - Clearing port E pull-up bit 1 drops the serial a receive pull-up.
// - Clearing port D pull-up bit 6 drops the serial b transmit pull-up.
// - Clearing port D pull-up bit 7 drops the serial b receive pull-up.
// - Setting the test-port pull-up disable bit drops TMS and TDI pull-ups.
// - The test clock, taken straight from its pad without gating, runs the test pad logic.
// - TMS is sampled on each rising test clock edge.
// - TDI is sampled on each rising test clock edge.
// - TDO drives only in shift-IR or shift-DR, else it floats.
// - TDO changes on the falling test clock edge.
module stpc_pad_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial controller side
  input wire logic serial_a_tx_data,
  input wire logic serial_b_tx_data,
  output logic serial_a_rx_data,
  output logic serial_b_rx_data,
  // Pads: index 0 a_tx, 1 a_rx, 2 b_tx, 3 b_rx
  input wire logic [3:0] serial_pad_in,
  output logic [3:0] serial_pad_out,
  output logic [3:0] serial_pad_oe,
  output logic [3:0] serial_pad_pullup_en,
  // Test port pads
  input wire logic test_clock,
  input wire logic test_mode_select,
  input wire logic test_data_in,
  output logic test_mode_pullup_en,
  output logic test_data_in_pullup_en,
  output logic test_data_out,
  output logic test_data_out_oe,
  output logic test_data_out_pullup_en,
  // Test logic side
  output logic test_mode_sampled,
  output logic test_data_in_sampled,
  input wire logic test_shift_state,
  input wire logic test_shift_data
);

  // ****************************************************************
  // Register file and bus slave
  // ****************************************************************
  logic [1:0] pe_pullup_q, pe_pullup_d;
  logic [1:0] pd_pullup_q, pd_pullup_d;
  logic sys_pud_q, sys_pud_d;
  logic [3:0] func_q, func_d;
  logic [3:0] dir_q, dir_d;
  logic [3:0] gpo_q, gpo_d;
  logic aw_held_q, aw_held_d;
  logic w_held_q, w_held_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [3:0] pad_s1_q, pad_s2_q;
  logic [31:0] rd_word;
  logic rd_hit;

  // Address match helper
  function automatic logic addr_is(input logic [11:0] a,
                                   input logic [11:0] r);
    addr_is = (a[11:2] == r[11:2]);
  endfunction

  // Ready while the slot is empty and no response waits
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Read decode
  always_comb begin
    rd_word = 32'h0;
    rd_hit = 1'b1;
    if (addr_is(s_axi_araddr[11:0], `STPC_PORT_E_PULLUP_ENABLE_ADDR)) begin
      rd_word[`STPC_PE_LINE_ZERO_BIT] = pe_pullup_q[0];
      rd_word[`STPC_PE_LINE_ONE_BIT] = pe_pullup_q[1];
    end else if (addr_is(s_axi_araddr[11:0],
                         `STPC_PORT_D_PULLUP_ENABLE_ADDR)) begin
      rd_word[`STPC_PD_LINE_SIX_BIT] = pd_pullup_q[0];
      rd_word[`STPC_PD_LINE_SEVEN_BIT] = pd_pullup_q[1];
    end else if (addr_is(s_axi_araddr[11:0],
                         `STPC_SYSTEM_PULLUP_DISABLE_ADDR)) begin
      rd_word[`STPC_SPD_TEST_PORT_BIT] = sys_pud_q;
    end else if (addr_is(s_axi_araddr[11:0], `STPC_PIN_FUNCTION_ADDR)) begin
      rd_word[3:0] = func_q;
    end else if (addr_is(s_axi_araddr[11:0], `STPC_GPIO_DIRECTION_ADDR)) begin
      rd_word[3:0] = dir_q;
    end else if (addr_is(s_axi_araddr[11:0], `STPC_GPIO_OUTPUT_ADDR)) begin
      rd_word[3:0] = gpo_q;
    end else if (addr_is(s_axi_araddr[11:0], `STPC_PIN_STATUS_ADDR)) begin
      rd_word[3:0] = pad_s2_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Next state of bus slave and registers
  always_comb begin
    logic wr_go;
    wr_go = 1'b0;
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    pe_pullup_d = pe_pullup_q;
    pd_pullup_d = pd_pullup_q;
    sys_pud_d = sys_pud_q;
    func_d = func_q;
    dir_d = dir_q;
    gpo_d = gpo_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      awaddr_d = s_axi_awaddr[11:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    wr_go = aw_held_q && w_held_q && !bvalid_q;
    if (wr_go) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = stpc_pkg::STPC_RESP_OKAY;
      if (!wstrb_q[0]) begin
        bresp_d = stpc_pkg::STPC_RESP_OKAY;
      end else if (addr_is(awaddr_q, `STPC_PORT_E_PULLUP_ENABLE_ADDR)) begin
        pe_pullup_d[0] = wdata_q[`STPC_PE_LINE_ZERO_BIT];
        pe_pullup_d[1] = wdata_q[`STPC_PE_LINE_ONE_BIT];
      end else if (addr_is(awaddr_q, `STPC_PORT_D_PULLUP_ENABLE_ADDR)) begin
        pd_pullup_d[0] = wdata_q[`STPC_PD_LINE_SIX_BIT];
        pd_pullup_d[1] = wdata_q[`STPC_PD_LINE_SEVEN_BIT];
      end else if (addr_is(awaddr_q, `STPC_SYSTEM_PULLUP_DISABLE_ADDR)) begin
        sys_pud_d = wdata_q[`STPC_SPD_TEST_PORT_BIT];
      end else if (addr_is(awaddr_q, `STPC_PIN_FUNCTION_ADDR)) begin
        func_d = wdata_q[3:0];
      end else if (addr_is(awaddr_q, `STPC_GPIO_DIRECTION_ADDR)) begin
        dir_d = wdata_q[3:0];
      end else if (addr_is(awaddr_q, `STPC_GPIO_OUTPUT_ADDR)) begin
        gpo_d = wdata_q[3:0];
      end else if (!addr_is(awaddr_q, `STPC_PIN_STATUS_ADDR)) begin
        bresp_d = stpc_pkg::STPC_RESP_SLVERR;
      end
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d = rd_word;
      rresp_d = rd_hit ? stpc_pkg::STPC_RESP_OKAY
                       : stpc_pkg::STPC_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Register update; reset gives serial function and pull-ups on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 12'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0;
      pe_pullup_q <= `STPC_PORT_E_PULLUP_RESET;
      pd_pullup_q <= `STPC_PORT_D_PULLUP_RESET;
      sys_pud_q <= `STPC_SYSTEM_PULLUP_RESET;
      func_q <= `STPC_PIN_FUNCTION_RESET;
      dir_q <= `STPC_GPIO_DIRECTION_RESET;
      gpo_q <= `STPC_GPIO_OUTPUT_RESET;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      pe_pullup_q <= pe_pullup_d;
      pd_pullup_q <= pd_pullup_d;
      sys_pud_q <= sys_pud_d;
      func_q <= func_d;
      dir_q <= dir_d;
      gpo_q <= gpo_d;
    end
  end

  // ****************************************************************
  // Serial pad mux
  // ****************************************************************
  // Pad input synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_s1_q <= 4'h0;
      pad_s2_q <= 4'h0;
    end else begin
      pad_s1_q <= serial_pad_in;
      pad_s2_q <= pad_s1_q;
    end
  end

  // Function select: serial function or GPIO per pin
  always_comb begin
    serial_pad_out = gpo_q;
    serial_pad_oe = 4'h0;
    if (!aresetn) begin
      serial_pad_oe = 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        serial_pad_oe[i] = func_q[i] && dir_q[i];
      end
      if (func_q[0] == stpc_pkg::STPC_FUNC_SERIAL) begin
        serial_pad_out[0] = serial_a_tx_data;
        serial_pad_oe[0] = 1'b1;
      end
      if (func_q[2] == stpc_pkg::STPC_FUNC_SERIAL) begin
        serial_pad_out[2] = serial_b_tx_data;
        serial_pad_oe[2] = 1'b1;
      end
    end
    serial_a_rx_data = func_q[1] ? 1'b1 : pad_s2_q[1];
    serial_b_rx_data = func_q[3] ? 1'b1 : pad_s2_q[3];
  end

  // Pull-up enables, forced on during system reset
  assign serial_pad_pullup_en[0] = !aresetn || pe_pullup_q[0];
  assign serial_pad_pullup_en[1] = !aresetn || pe_pullup_q[1];
  assign serial_pad_pullup_en[2] = !aresetn || pd_pullup_q[0];
  assign serial_pad_pullup_en[3] = !aresetn || pd_pullup_q[1];
  assign test_mode_pullup_en = !aresetn || !sys_pud_q;
  assign test_data_in_pullup_en = !aresetn || !sys_pud_q;
  assign test_data_out_pullup_en = 1'b1;

  // ****************************************************************
  // Test port pad timing, test clock domain
  // ****************************************************************
  logic tms_q, tdi_q;
  logic tdo_q, tdo_oe_q;
  logic rst_s1_q, rst_s2_q;

  // System reset carried into the test clock domain
  always_ff @(posedge test_clock) begin
    rst_s1_q <= aresetn;
    rst_s2_q <= rst_s1_q;
  end

  // Rising edge capture of TMS and TDI
  always_ff @(posedge test_clock) begin
    tms_q <= test_mode_select;
    tdi_q <= test_data_in;
  end
  assign test_mode_sampled = tms_q;
  assign test_data_in_sampled = tdi_q;

  // Falling edge launch of TDO and its enable
  always_ff @(negedge test_clock) begin
    tdo_q <= test_shift_data;
    tdo_oe_q <= test_shift_state;
  end
  assign test_data_out = tdo_q;
  assign test_data_out_oe = tdo_oe_q && rst_s2_q && aresetn;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_tx_default;
    @(posedge aclk) $rose(aresetn) |-> serial_pad_oe[0] && serial_pad_oe[2];
  endproperty
  a_tx_default: assert property (p_tx_default)
    else $error("transmit pad not serial after reset");

  property p_rx_default;
    @(posedge aclk) disable iff (!aresetn)
      func_q[3] == 1'b0 |-> serial_b_rx_data == pad_s2_q[3];
  endproperty
  a_rx_default: assert property (p_rx_default)
    else $error("serial b receive not routed");

  property p_gpio_dir;
    @(posedge aclk) disable iff (!aresetn)
      func_q[1] |-> serial_pad_oe[1] == dir_q[1];
  endproperty
  a_gpio_dir: assert property (p_gpio_dir)
    else $error("gpio direction ignored");

  property p_pe0;
    @(posedge aclk) disable iff (!aresetn)
      serial_pad_pullup_en[0] == pe_pullup_q[0];
  endproperty
  a_pe0: assert property (p_pe0)
    else $error("port e bit 0 pull-up wrong");

  property p_pd7;
    @(posedge aclk) disable iff (!aresetn)
      serial_pad_pullup_en[3] == pd_pullup_q[1];
  endproperty
  a_pd7: assert property (p_pd7)
    else $error("port d bit 7 pull-up wrong");

  property p_test_pud;
    @(posedge aclk) disable iff (!aresetn)
      sys_pud_q |-> !test_mode_pullup_en && !test_data_in_pullup_en;
  endproperty
  a_test_pud: assert property (p_test_pud)
    else $error("test pull-ups not disabled");

  property p_tdo_oe;
    @(negedge test_clock) disable iff (!rst_s2_q)
      !test_shift_state |=> !test_data_out_oe;
  endproperty
  a_tdo_oe: assert property (p_tdo_oe)
    else $error("tdo enabled outside shift");

  property p_reset_float;
    @(posedge aclk) !aresetn |-> serial_pad_oe == 4'h0 &&
      !test_data_out_oe && serial_pad_pullup_en == 4'hf;
  endproperty
  a_reset_float: assert property (p_reset_float)
    else $error("pad driven during reset");

endmodule

// ---- stpc_pkg.sv ----
package stpc_pkg;
  // AXI response codes
  typedef enum logic [1:0] {
    STPC_RESP_OKAY = 2'h0,
    STPC_RESP_SLVERR = 2'h2
  } stpc_resp_t;
  // Pin function select per serial pin
  typedef enum logic {
    STPC_FUNC_SERIAL,
    STPC_FUNC_GPIO
  } stpc_func_t;
endpackage
